/* File: tbh_host.sv */
// Host controller that drives the Type B reader through its mode 0 SPI port.
`timescale 1ns/100ps
`include "tbh_defines.svh"
module tbh_host #(
  parameter int HALF_CYC = `TBH_SPI_HALF_CYC,
  parameter int SETTLE_CYC = `TBH_SETTLE_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire tbh_pkg::tbh_byte_t cmd_data_i,
  input wire logic cmd_last_i,
  output logic cmd_ready_o,
  input wire tbh_pkg::tbh_fwt_t fwt_cycles_i,
  output tbh_pkg::tbh_byte_t rsp_data_o,
  output logic rsp_valid_o,
  output logic rsp_timeout_o,
  output logic busy_o,
  output logic serial_clock_o,
  output logic serial_in_line_o,
  output logic slave_select_low_o,
  input wire logic serial_out_line_i,
  input wire logic host_handshake_status_i
);
  import tbh_pkg::*;

  tbh_state_t state;
  logic hs_meta;
  logic hs_sync;
  logic miso_meta;
  logic miso_sync;
  logic sh_start;
  tbh_byte_t sh_tx;
  logic sh_busy;
  logic sh_done;
  tbh_byte_t sh_rx;
  logic last_byte;
  logic [15:0] wait_cnt;
  tbh_fwt_t fwt_cnt;
  logic cmd_take;

  // Pins from the reader are asynchronous to mclk_i; two flops before any use.
  // Read bits are sampled from the synchronised copy, which lags the pin by two
  // cycles, so a serial clock half period must be at least three cycles long.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      hs_meta <= 1'b0;
      hs_sync <= 1'b0;
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
    end
    else
    begin
      hs_meta <= host_handshake_status_i;
      hs_sync <= hs_meta;
      miso_meta <= serial_out_line_i;
      miso_sync <= miso_meta;
    end
  end

  // A command byte is only taken while no reply byte is pending.
  assign cmd_ready_o = ((state == TBH_IDLE) || (state == TBH_TX_GAP)) && !hs_sync;
  assign cmd_take = cmd_valid_i && cmd_ready_o;
  assign busy_o = (state != TBH_IDLE);

  // Byte shifter; it returns the serial clock low between bytes.
  tbh_spi_shift #(
    .HALF_CYC(HALF_CYC)
  ) u_shift (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(sh_start),
    .tx_byte_i(sh_tx),
    .miso_i(miso_sync),
    .busy_o(sh_busy),
    .done_o(sh_done),
    .rx_byte_o(sh_rx),
    .sclk_o(serial_clock_o),
    .mosi_o(serial_in_line_o)
  );

  // Transfer sequencer. Reading has priority over starting a new command.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state <= TBH_IDLE;
      slave_select_low_o <= 1'b1;
      sh_start <= 1'b0;
      sh_tx <= '0;
      last_byte <= 1'b0;
      wait_cnt <= '0;
    end
    else
    begin
      sh_start <= 1'b0;
      case (state)
        TBH_IDLE:
        begin
          wait_cnt <= '0;
          if (hs_sync)
          begin
            slave_select_low_o <= 1'b0;
            state <= TBH_RX_SETUP;
          end
          else if (cmd_take)
          begin
            slave_select_low_o <= 1'b0;
            sh_tx <= cmd_data_i;
            last_byte <= cmd_last_i;
            state <= TBH_TX_SETUP;
          end
        end
        TBH_TX_SETUP:
        begin
          wait_cnt <= wait_cnt + 16'd1;
          if (wait_cnt == 16'(`TBH_SEL_SETUP_CYC))
          begin
            sh_start <= 1'b1;
            state <= TBH_TX_BYTE;
          end
        end
        TBH_TX_BYTE:
        begin
          wait_cnt <= '0;
          if (sh_done)
          begin
            if (last_byte)
            begin
              slave_select_low_o <= 1'b1;
              state <= TBH_WAIT_RESP;
            end
            else
              state <= TBH_TX_GAP;
          end
        end
        TBH_TX_GAP:
        begin
          if (cmd_take)
          begin
            sh_tx <= cmd_data_i;
            last_byte <= cmd_last_i;
            sh_start <= 1'b1;
            state <= TBH_TX_BYTE;
          end
        end
        TBH_WAIT_RESP:
        begin
          if (hs_sync)
          begin
            slave_select_low_o <= 1'b0;
            state <= TBH_RX_SETUP;
          end
          else if (fwt_cnt >= fwt_cycles_i)
            state <= TBH_IDLE;
        end
        TBH_RX_SETUP:
        begin
          wait_cnt <= wait_cnt + 16'd1;
          if (wait_cnt == 16'(`TBH_SEL_SETUP_CYC))
          begin
            sh_tx <= `TBH_DUMMY_BYTE;
            sh_start <= 1'b1;
            state <= TBH_RX_BYTE;
          end
        end
        TBH_RX_BYTE:
        begin
          wait_cnt <= '0;
          if (sh_done)
          begin
            slave_select_low_o <= 1'b1;
            state <= TBH_RX_SETTLE;
          end
        end
        TBH_RX_SETTLE:
        begin
          // Give the handshake time to drop and cross the synchroniser, so the
          // byte just read is not mistaken for the next one.
          wait_cnt <= wait_cnt + 16'd1;
          if (wait_cnt == 16'(SETTLE_CYC))
            state <= TBH_IDLE;
        end
        default:
          state <= TBH_IDLE;
      endcase
    end
  end

  // Frame waiting time counter; runs only while a reply is awaited.
  // The card's guard time and its silence before a whole frame both fall inside
  // this window, so only the handshake or the limit can end the wait.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || (state != TBH_WAIT_RESP))
      fwt_cnt <= '0;
    else if (fwt_cnt != '1)
      fwt_cnt <= fwt_cnt + 32'd1;
  end

  // Reply bytes and the timeout flag are registered one-cycle events.
  // The reader strips RF framing and CRC, so payload bytes and then the reader's status byte arrive here.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rsp_data_o <= '0;
      rsp_valid_o <= 1'b0;
      rsp_timeout_o <= 1'b0;
    end
    else
    begin
      rsp_valid_o <= (state == TBH_RX_BYTE) && sh_done;
      rsp_timeout_o <= (state == TBH_WAIT_RESP) && !hs_sync && (fwt_cnt >= fwt_cycles_i);
      if ((state == TBH_RX_BYTE) && sh_done)
        rsp_data_o <= sh_rx;
    end
  end

  a_clock_idle_low: assert property (@(posedge mclk_i) disable iff (rst_i)
    slave_select_low_o |-> !serial_clock_o)
    else $error("Serial clock high while reader deselected.");

  a_no_cmd_pending: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_take |-> !hs_sync)
    else $error("Command byte taken while a reply byte was pending.");

  a_read_first: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state == TBH_IDLE) && hs_sync |=> (state == TBH_RX_SETUP) && !slave_select_low_o)
    else $error("Pending reply byte not read first.");

  a_quiet_waiting: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state == TBH_WAIT_RESP) |-> slave_select_low_o && !sh_busy)
    else $error("Transfer started while awaiting the card reply.");

  a_fwt_timeout: assert property (@(posedge mclk_i) disable iff (rst_i)
    rsp_timeout_o |-> $past(fwt_cnt) >= $past(fwt_cycles_i))
    else $error("Timeout reported before the frame waiting time.");

  a_byte_delivered: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state == TBH_RX_BYTE) && sh_done |=> rsp_valid_o && (rsp_data_o == $past(sh_rx)))
    else $error("Read byte not delivered on the next cycle.");

  a_settle_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(state == TBH_RX_SETTLE) |-> slave_select_low_o [*8])
    else $error("Reader selected again during handshake settle.");
endmodule

/* File: tbh_defines.svh */
// Timing and encoding constants for the Type B reader host controller.
`ifndef TBH_DEFINES_SVH
`define TBH_DEFINES_SVH

`define TBH_CLK_NS 5
`define TBH_SPI_HALF_NS 250
`define TBH_SPI_HALF_CYC ((`TBH_SPI_HALF_NS + `TBH_CLK_NS - 1) / `TBH_CLK_NS)
`define TBH_SETTLE_NS 100
`define TBH_SETTLE_CYC ((`TBH_SETTLE_NS + `TBH_CLK_NS - 1) / `TBH_CLK_NS)
`define TBH_SEL_SETUP_CYC 4
`define TBH_DUMMY_BYTE 8'h00
`define TBH_BYTE_BITS 8
`define TBH_FWT_W 32

`endif

/* File: tbh_pkg.sv */
// Types shared by the Type B reader host controller.
package tbh_pkg;
  typedef logic [7:0] tbh_byte_t;
  typedef logic [31:0] tbh_fwt_t;
  typedef enum logic [2:0] {
    TBH_IDLE,
    TBH_TX_SETUP,
    TBH_TX_BYTE,
    TBH_TX_GAP,
    TBH_WAIT_RESP,
    TBH_RX_SETUP,
    TBH_RX_BYTE,
    TBH_RX_SETTLE
  } tbh_state_t;
endpackage

/* File: tbh_spi_shift.sv */
// Mode 0 SPI master byte shifter with its own serial clock divider.
`timescale 1ns/100ps
`include "tbh_defines.svh"
module tbh_spi_shift #(
  parameter int HALF_CYC = `TBH_SPI_HALF_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire tbh_pkg::tbh_byte_t tx_byte_i,
  input wire logic miso_i,
  output logic busy_o,
  output logic done_o,
  output tbh_pkg::tbh_byte_t rx_byte_o,
  output logic sclk_o,
  output logic mosi_o
);
  import tbh_pkg::*;

  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] DIV_LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] div;
  logic tick;
  logic [2:0] bitn;
  tbh_byte_t txsh;
  logic [3:0] rise_cnt;

  // Half-period enable pulse; the divider only runs while a byte is in flight.
  assign tick = busy_o && (div == DIV_LAST);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !busy_o)
      div <= '0;
    else if (tick)
      div <= '0;
    else
      div <= div + 1'b1;
  end

  // First bit is set up before the first rising edge, later bits on falling edges.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      bitn <= '0;
      txsh <= '0;
      rx_byte_o <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i && !busy_o)
      begin
        busy_o <= 1'b1;
        sclk_o <= 1'b0;
        mosi_o <= tx_byte_i[7];
        txsh <= {tx_byte_i[6:0], 1'b0};
        bitn <= '0;
      end
      else if (tick)
      begin
        if (!sclk_o)
        begin
          sclk_o <= 1'b1;
          rx_byte_o <= {rx_byte_o[6:0], miso_i};
        end
        else
        begin
          sclk_o <= 1'b0;
          if (bitn == 3'(`TBH_BYTE_BITS - 1))
          begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
          else
          begin
            bitn <= bitn + 3'd1;
            mosi_o <= txsh[7];
            txsh <= {txsh[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Counts rising serial clock edges of the current byte for checking only.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || (start_i && !busy_o))
      rise_cnt <= '0;
    else if (tick && !sclk_o)
      rise_cnt <= rise_cnt + 4'd1;
  end

  a_mosi_rise_stable: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(sclk_o) |-> $stable(mosi_o))
    else $error("Serial data changed on a rising clock edge.");

  a_eight_clock_byte: assert property (@(posedge mclk_i) disable iff (rst_i)
    done_o |-> (rise_cnt == 4'(`TBH_BYTE_BITS)) && !sclk_o)
    else $error("Byte did not take exactly eight serial clocks.");

  a_clock_low_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
    !busy_o |-> !sclk_o)
    else $error("Serial clock high while shifter idle.");
endmodule

/* File: tbh_reader_model.sv */
// Behavioural model of the reader's mode 0 SPI slave port and its reply handshake.
`timescale 1ns/100ps
module tbh_reader_model #(
  parameter int REPLY_NS = 1000,
  parameter int GAP_NS = 500
) (
  input wire logic serial_clock_i,
  input wire logic serial_in_line_i,
  input wire logic slave_select_low_i,
  input wire logic silent_i,
  output logic serial_out_line_o,
  output logic host_handshake_status_o
);
  import tbh_pkg::*;
  tbh_byte_t cmd[$];
  tbh_byte_t reply[$];
  tbh_byte_t shift = 8'h00;
  tbh_byte_t out = 8'h00;
  int nbits = 0;
  logic reading = 1'b0;
  logic obit = 1'b1;
  initial host_handshake_status_o = 1'b0;

  // A released line has no keeper, so it shows the inverse of the last bit.
  assign serial_out_line_o = slave_select_low_i ? ~obit : obit;

  // A transfer that opens with the handshake high is a reply read.
  always @(negedge slave_select_low_i)
  begin
    reading = host_handshake_status_o;
    nbits = 0;
    if (reading && reply.size() > 0)
      out = reply[0];
    obit = out[7];
  end

  // Bits are taken on the rising clock only while selected.
  always @(posedge serial_clock_i)
  begin
    if (!slave_select_low_i)
    begin
      shift = {shift[6:0], serial_in_line_i};
      nbits++;
      if (nbits == 8)
      begin
        nbits = 0;
        if (reading)
        begin
          void'(reply.pop_front());
          host_handshake_status_o = 1'b0;
          if (reply.size() > 0)
            fork
              #(GAP_NS) host_handshake_status_o = 1'b1;
            join_none
        end
        else if (reply.size() == 0)
          cmd.push_back(shift); // Unread output blocks new commands.
      end
    end
  end

  // Output bits change on the falling clock edge.
  always @(negedge serial_clock_i)
    if (!slave_select_low_i && reading && nbits > 0)
      obit = out[7 - nbits];

  // A finished command is echoed with a clean status byte, unless the card is silent.
  always @(posedge slave_select_low_i)
    if (!reading && cmd.size() > 0)
    begin
      // The reader frames the command with its own CRC, preset to all ones over
      // polynomial 1021; the host never supplies one.
      reply = cmd;
      reply.push_back(8'h00); // Frame check result, zero when clean.
      cmd.delete();
      if (!silent_i)
        fork
          #(REPLY_NS) host_handshake_status_o = 1'b1;
        join_none
      else
        reply.delete();
    end
endmodule

/* File: tb.sv */
// Self-checking testbench for the Type B reader host controller.
`timescale 1ns/100ps
`define CHK(a, e) \
  begin \
    checked++; \
    if ((a) !== (e)) \
    begin \
      n_fail++; \
      $display("BAD t=%0t got=%h exp=%h", $time, a, e); \
    end \
  end
module tb;
  import tbh_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid = 1'b0;
  tbh_byte_t cmd_data = 8'h00;
  logic cmd_last = 1'b0;
  tbh_fwt_t fwt = 32'h0001_0000;
  logic silent = 1'b0;
  logic cmd_ready, rsp_valid, rsp_timeout, busy, sclk, mosi, sel_low, miso, hs;
  tbh_byte_t rsp_data;
  int checked = 0;
  int n_fail = 0;
  int sck_n = 0;
  int sel_falls = 0;
  int valids = 0;

  // The clock runs at 200 MHz.
  always #2.5 mclk_i = ~mclk_i;

  // Half period of four cycles: the read path needs at least three.
  tbh_host #(.HALF_CYC(4)) uut (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
    .cmd_data_i(cmd_data), .cmd_last_i(cmd_last), .cmd_ready_o(cmd_ready),
    .fwt_cycles_i(fwt), .rsp_data_o(rsp_data), .rsp_valid_o(rsp_valid),
    .rsp_timeout_o(rsp_timeout), .busy_o(busy), .serial_clock_o(sclk),
    .serial_in_line_o(mosi), .slave_select_low_o(sel_low), .serial_out_line_i(miso),
    .host_handshake_status_i(hs));

  tbh_reader_model rdr (.serial_clock_i(sclk), .serial_in_line_i(mosi),
    .slave_select_low_i(sel_low), .silent_i(silent), .serial_out_line_o(miso),
    .host_handshake_status_o(hs));

  // Watch the serial port: clock edges per selection and selections started.
  always @(posedge sclk) sck_n++;
  always @(negedge sel_low) sel_falls++;
  always @(posedge mclk_i) if (rsp_valid === 1'b1) valids++;

  // Each selection ends with the clock idle low after whole bytes.
  always @(posedge sel_low)
    if (!rst_i)
    begin
      `CHK(sclk, 1'b0)
      `CHK(sck_n % 8 == 0 && sck_n > 0, 1'b1)
      sck_n = 0;
    end

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Waits for a reply pulse (0) or a timeout pulse (1); a spent bound ends the run.
  task automatic wait_pulse(input bit which, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while ((which ? rsp_timeout : rsp_valid) !== 1'b1 && n < lim);
    if ((which ? rsp_timeout : rsp_valid) !== 1'b1)
    begin
      n_fail++;
      stop_test();
    end
  endtask

  // Offers each byte and holds it until an edge samples ready high.
  task automatic send_cmd(input tbh_byte_t b[$]);
    int n;
    for (int i = 0; i < b.size(); i++)
    begin
      cmd_valid <= 1'b1;
      cmd_data <= b[i];
      cmd_last <= (i == b.size() - 1);
      n = 0;
      do
      begin
        @(posedge mclk_i);
        n++;
      end
      while (cmd_ready !== 1'b1 && n < 20000);
      if (cmd_ready !== 1'b1)
      begin
        n_fail++;
        stop_test();
      end
    end
    cmd_valid <= 1'b0;
    cmd_last <= 1'b0;
  endtask

  task automatic t_reset;
    @(posedge mclk_i);
    `CHK(sel_low, 1'b1)
    `CHK(sclk, 1'b0)
    `CHK(busy, 1'b0)
    `CHK(cmd_ready, 1'b1)
  endtask

  // Sends a command, then reads back the echo and the status byte in order.
  task automatic t_exchange(input tbh_byte_t c[$]);
    tbh_byte_t e[$];
    int n;
    int v0;
    e = c;
    e.push_back(8'h00);
    v0 = valids;
    send_cmd(c);
    foreach (e[i])
    begin
      wait_pulse(1'b0, 5000, n);
      `CHK(rsp_data, e[i])
    end
    repeat (300) @(posedge mclk_i);
    `CHK(valids - v0, e.size())
    `CHK(busy, 1'b0)
  endtask

  // A silent card: the wait ends at the limit with no further transfer.
  task automatic t_timeout;
    int n;
    int s0;
    int v0;
    silent <= 1'b1;
    fwt <= 32'd400;
    @(posedge mclk_i);
    send_cmd('{8'h05});
    // The command's own selection falls in this time step, after this read.
    s0 = sel_falls + 1;
    v0 = valids;
    wait_pulse(1'b1, 700, n);
    `CHK(n >= 400, 1'b1)
    `CHK(sel_falls, s0)
    `CHK(valids, v0)
    silent <= 1'b0;
    fwt <= 32'h0001_0000;
    repeat (20) @(posedge mclk_i);
  endtask

  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_exchange('{8'ha5, 8'h3c, 8'h81});
    t_exchange('{8'hff});
    t_timeout();
    t_exchange('{8'h00, 8'h7e});
    stop_test();
  end
endmodule
